// ---- core/cdr_pkg.sv ----
// Shared constants and types for the clock-recovery demultiplexer model.
// Assumes every importer runs on the single system clock.
package cdr_pkg;
  // Band select codes that switch the oscillator off
  localparam logic [2:0] BAND_OFF_LOW  = 3'h0;
  localparam logic [2:0] BAND_OFF_HIGH = 3'h7;
  localparam int         OSC_COUNT     = 6;
  // Band edges in units of 0.1 GHz, lowest and highest band
  localparam int         BAND_LOW_MIN  = 167;
  localparam int         BAND_HIGH_MAX = 399;
  // Frequency monitor
  localparam int         REF_DIVIDE         = 32;
  localparam int         REF_WINDOW_PERIODS = 32;
  localparam int         LOCK_TOL_PPM       = 1000;
  localparam int         PPM_SCALE          = 1000000;
  // Charge pump shortfall below maximum, in units of 10 uA
  localparam int         PUMP_WIDTH    = 5;
  localparam logic [4:0] PUMP_DEF_00   = 5'h1F;
  localparam logic [4:0] PUMP_DEF_01   = 5'h1B;
  localparam logic [4:0] PUMP_DEF_10   = 5'h04;
  localparam logic [4:0] PUMP_DEF_11   = 5'h00;
  localparam int         BIAS_WIDTH    = 8;
  // Data path
  localparam int         LANE_WIDTH    = 2;
  localparam int         BUFFER_DEPTH  = 2;
  localparam int         EVEN_LANE     = 0;
  localparam int         ODD_LANE      = 1;
  localparam logic       POL_DIRECT    = 1'b1;
  localparam logic       REF_MODE_LVDS = 1'b1;

  typedef enum logic {
    HALF_LOW  = 1'b0,
    HALF_HIGH = 1'b1
  } half_phase_t;
endpackage

// ---- core/lane_word_if.sv ----
// Carrier for two-bit demultiplexed words between internal stages.
// Assumes source and sink share the system clock.
`timescale 1ns/1ps
interface lane_word_if #(parameter int WIDTH = 2) ();
  logic [WIDTH-1:0] word;
  logic             valid;
  logic             ready;
  modport source (output word, output valid, input ready);
  modport sink   (input word, input valid, output ready);
endinterface

// ---- core/lane_buffer.sv ----
// Small word buffer with valid and ready on both sides.
// Assumes the filling side holds its word until ready is seen.
`timescale 1ns/1ps
module lane_buffer
  import cdr_pkg::*;
#(
  parameter int WIDTH = LANE_WIDTH,
  parameter int DEPTH = BUFFER_DEPTH
) (
  // Clock and reset
  input wire logic    clk_i,
  input wire logic    rst_i,
  // Word sides
  lane_word_if.sink   fill,
  lane_word_if.source drain
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] slot;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [CW-1:0]               count;
  } buf_state_t;

  buf_state_t st;
  buf_state_t next_st;
  logic       push;
  logic       pop;

  assign fill.ready  = (st.count != CW'(DEPTH));
  assign drain.valid = (st.count != '0);
  assign drain.word  = st.slot[st.rd];

  always_comb begin
    next_st = st;
    push = fill.valid && fill.ready;
    pop = drain.ready && drain.valid;
    if (push) begin
      next_st.slot[st.wr] = fill.word;
      next_st.wr = (st.wr == PW'(DEPTH - 1)) ? '0 : st.wr + PW'(1);
    end
    if (pop) begin
      next_st.rd = (st.rd == PW'(DEPTH - 1)) ? '0 : st.rd + PW'(1);
    end
    if (push && !pop) begin
      next_st.count = st.count + CW'(1);
    end else if (pop && !push) begin
      next_st.count = st.count - CW'(1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  buffer_fill_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (push && !pop) |=> (st.count == $past(st.count) + CW'(1)))
    else $error("buffer count missed a push");
  buffer_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.count == CW'(DEPTH)) |-> (!fill.ready && drain.valid))
    else $error("full buffer still accepts");
endmodule

// ---- core/lock_monitor.sv ----
// Compares recovered clock cycles against reference periods.
// Assumes the reference level is already synchronous to the clock.
`timescale 1ns/1ps
module lock_monitor
  import cdr_pkg::*;
#(
  parameter int RATIO   = REF_DIVIDE,
  parameter int PERIODS = REF_WINDOW_PERIODS,
  parameter int TOL_PPM = LOCK_TOL_PPM
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Status
  input wire logic run_i,
  input wire logic ref_i,
  output logic     fail_o
);
  localparam int EXPECT = RATIO * PERIODS;
  localparam int TOL    = EXPECT * TOL_PPM / PPM_SCALE;
  localparam int LIMIT  = EXPECT + TOL + 1;
  localparam int CW     = $clog2(LIMIT + 2);
  localparam int PW     = $clog2(PERIODS + 1);

  typedef struct packed {
    logic          ref_q;
    logic          started;
    logic [CW-1:0] cycles;
    logic [PW-1:0] periods;
    logic          fail;
  } mon_state_t;

  mon_state_t    st;
  mon_state_t    next_st;
  logic          rise;
  logic          closing;
  logic [CW-1:0] elapsed;

  assign fail_o = st.fail;

  always_comb begin
    next_st = st;
    rise = ref_i && !st.ref_q;
    elapsed = st.cycles + CW'(1);
    closing = st.started && rise && (st.periods == PW'(PERIODS - 1));
    next_st.ref_q = ref_i;
    if (!run_i) begin
      next_st.started = 1'b0;
      next_st.cycles = '0;
      next_st.periods = '0;
      next_st.fail = 1'b1;
    end else if (rise && !st.started) begin
      next_st.started = 1'b1;
      next_st.cycles = '0;
      next_st.periods = '0;
    end else if (closing) begin
      // [R4] Window judged both ways
      next_st.fail = (elapsed > CW'(EXPECT + TOL)) || (elapsed < CW'(EXPECT - TOL));
      next_st.cycles = '0;
      next_st.periods = '0;
    end else if (st.started) begin
      // Reference stopped or far too slow: alarm and resync
      if (st.cycles == CW'(LIMIT)) begin
        next_st.fail = 1'b1;
        next_st.started = 1'b0;
      end else begin
        next_st.cycles = elapsed;
        if (rise) begin
          next_st.periods = st.periods + PW'(1);
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
      st.fail <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  window_wide_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    (run_i && closing && ((elapsed > CW'(EXPECT + TOL)) || (elapsed < CW'(EXPECT - TOL))))
    |=> fail_o)
    else $error("frequency error not flagged");
  window_good_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    (run_i && closing && (elapsed <= CW'(EXPECT + TOL)) && (elapsed >= CW'(EXPECT - TOL)))
    |=> !fail_o)
    else $error("in-tolerance window flagged");
  monitor_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R19]
    !run_i |=> fail_o)
    else $error("alarm clear while oscillator off");
endmodule

// ---- core/cdr_demux_one_to_two.sv ----
// Clock-recovery demultiplexer: retimes a serial stream, splits it into
// two half-rate lanes, watches frequency lock against a reference.
// Assumes one serial bit per system clock and synchronous control pins.
// What this block does
// [R1] Band codes 1-6 enable one of six oscillators; codes 0 and 7 switch off.
// [R2] Bands 1-6 rise and overlap, spanning at least 16.7 to 39.9 GHz.
// [R3] The partner supplies a reference at one thirty-second of the oscillator rate.
// [R4] Alarm when recovered clock over 32 differs from reference beyond 1000 ppm.
// [R5] Pump bits set current at max minus 0.31, 0.27, 0.04 mA, or max.
// [R6] Follower bias current grows linearly with the control byte.
// [R7] Recovered clock samples each data bit at its centre.
// [R8] Recovered clock divided by two forms the half-rate clock for demux.
// [R9] Demux captures consecutive bits on both half-clock edges into 2-bit words.
// [R10] Lane swap exchanges which output lane carries which bit.
// [R11] Polarity 1 passes, 0 inverts full-rate and both half-rate outputs.
// [R12] Reference input is CML single-ended when low, LVDS differential when high.
// [R13] Full data, half clock and half data outputs each have their own enable.
// [R14] Partner may blindly toggle lane swap and must find correct order itself.
// [R15] Half-rate clock output is tightly phase aligned with the lane outputs.
// [R16] Retimed full-rate data also appears on its own output.
// [R17] Each enable bit turns its buffer on at 1, off at 0.
// [R18] Half clock falling edge coincides with lane data transitions.
// [R19] Off band code keeps the alarm set and data outputs static.
`timescale 1ns/1ps
module cdr_demux_one_to_two
  import cdr_pkg::*;
#(
  parameter int RATIO   = REF_DIVIDE,
  parameter int PERIODS = REF_WINDOW_PERIODS,
  parameter int TOL_PPM = LOCK_TOL_PPM
) (
  // Clock and reset
  input wire logic                   CLK_SYS_I,
  input wire logic                   SYS_RST_I,
  // Serial line and reference
  input wire logic                   SERIAL_IN_POS_I,
  input wire logic                   SERIAL_IN_NEG_I,
  input wire logic                   REFERENCE_CLOCK_POS_I,
  input wire logic                   REFERENCE_CLOCK_NEG_I,
  // Loop controls
  input wire logic [2:0]             BAND_SELECT_I,
  input wire logic                   PUMP_COARSE_I,
  input wire logic                   PUMP_FINE_I,
  input wire logic [BIAS_WIDTH-1:0]  FOLLOWER_CURRENT_I,
  input wire logic                   REF_MODE_LVDS_I,
  // Output controls
  input wire logic                   POLARITY_DIRECT_I,
  input wire logic                   LANE_SWAP_I,
  input wire logic                   FULL_DATA_OUT_ENABLE_I,
  input wire logic                   HALF_CLOCK_OUT_ENABLE_I,
  input wire logic                   HALF_DATA_OUT_ENABLE_I,
  input wire logic                   HALF_READY_I,
  // Full-rate data
  output logic                       FULL_DATA_OUT_POS_O,
  output logic                       FULL_DATA_OUT_NEG_O,
  // Half-rate lanes and clock
  output logic                       EVEN_LANE_OUT_POS_O,
  output logic                       EVEN_LANE_OUT_NEG_O,
  output logic                       ODD_LANE_OUT_POS_O,
  output logic                       ODD_LANE_OUT_NEG_O,
  output logic                       HALF_CLOCK_OUT_POS_O,
  output logic                       HALF_CLOCK_OUT_NEG_O,
  output logic                       HALF_VALID_O,
  // Loop status and analog settings
  output logic                       LOSS_OF_LOCK_O,
  output logic [OSC_COUNT-1:0]       OSC_ENABLE_O,
  output logic [PUMP_WIDTH-1:0]      PUMP_DEFICIT_O,
  output logic [BIAS_WIDTH-1:0]      FOLLOWER_BIAS_O,
  output logic                       REF_TERM_SINGLE_O,
  output logic                       REF_TERM_DIFF_O
);
  typedef struct packed {
    logic                  retimed;
    half_phase_t           demux_phase;
    logic                  even_hold;
    logic [LANE_WIDTH-1:0] word;
    logic                  word_valid;
    half_phase_t           out_phase;
    logic [LANE_WIDTH-1:0] lane_bits;
    logic                  full_pos;
    logic                  full_neg;
    logic                  even_pos;
    logic                  even_neg;
    logic                  odd_pos;
    logic                  odd_neg;
    logic                  hclk_pos;
    logic                  hclk_neg;
    logic                  valid;
    logic                  lol;
    logic [OSC_COUNT-1:0]  osc_en;
    logic [PUMP_WIDTH-1:0] deficit;
    logic [BIAS_WIDTH-1:0] bias;
    logic                  term_single;
    logic                  term_diff;
    logic                  ref_level;
  } top_state_t;

  top_state_t            st;
  top_state_t            next_st;
  logic                  osc_on;
  logic                  serial_bit;
  logic                  demux_advance;
  logic                  take;
  logic                  mon_fail;
  logic [LANE_WIDTH-1:0] lanes;
  logic                  invert;

  lane_word_if #(.WIDTH(LANE_WIDTH)) demux_link ();
  lane_word_if #(.WIDTH(LANE_WIDTH)) out_link ();

  lane_buffer #(
    .WIDTH (LANE_WIDTH),
    .DEPTH (BUFFER_DEPTH)
  ) u_buffer (
    .clk_i (CLK_SYS_I),
    .rst_i (SYS_RST_I),
    .fill  (demux_link),
    .drain (out_link)
  );

  lock_monitor #(
    .RATIO   (RATIO),
    .PERIODS (PERIODS),
    .TOL_PPM (TOL_PPM)
  ) u_monitor (
    .clk_i  (CLK_SYS_I),
    .rst_i  (SYS_RST_I),
    .run_i  (osc_on),
    .ref_i  (st.ref_level),
    .fail_o (mon_fail)
  );

  assign osc_on = (BAND_SELECT_I != BAND_OFF_LOW) && (BAND_SELECT_I != BAND_OFF_HIGH);
  assign serial_bit = SERIAL_IN_POS_I && !SERIAL_IN_NEG_I;
  assign invert = (POLARITY_DIRECT_I != POL_DIRECT);
  assign demux_link.word = st.word;
  assign demux_link.valid = st.word_valid;
  // Drain only at the top of a half clock, so data moves on its falling edge
  assign out_link.ready = osc_on && (st.out_phase == HALF_HIGH) && HALF_READY_I;

  always_comb begin
    next_st = st;
    take = out_link.valid && out_link.ready;
    demux_advance = !st.word_valid || demux_link.ready;
    lanes = out_link.word;
    // [R1] Band code decode
    for (int i = 0; i < OSC_COUNT; i++) begin
      next_st.osc_en[i] = (BAND_SELECT_I == 3'(i + 1));
    end
    // [R5] Pump current table
    unique case ({PUMP_COARSE_I, PUMP_FINE_I})
      2'b00: next_st.deficit = PUMP_DEF_00;
      2'b01: next_st.deficit = PUMP_DEF_01;
      2'b10: next_st.deficit = PUMP_DEF_10;
      2'b11: next_st.deficit = PUMP_DEF_11;
    endcase
    // [R6] Linear follower bias
    next_st.bias = osc_on ? FOLLOWER_CURRENT_I : '0;
    // [R12] Reference termination and receiver mode
    next_st.term_single = (REF_MODE_LVDS_I != REF_MODE_LVDS);
    next_st.term_diff = (REF_MODE_LVDS_I == REF_MODE_LVDS);
    if (REF_MODE_LVDS_I == REF_MODE_LVDS) begin
      next_st.ref_level = REFERENCE_CLOCK_POS_I && !REFERENCE_CLOCK_NEG_I;
    end else begin
      next_st.ref_level = REFERENCE_CLOCK_POS_I;
    end
    // [R4] Alarm from the frequency monitor
    next_st.lol = mon_fail || !osc_on;
    // [R19] With no oscillator the data-side registers hold, but the buffer can still take the held word
    if (osc_on) begin
      // [R7] Sampling point taken as bit centre
      next_st.retimed = serial_bit;
      if (st.word_valid && demux_link.ready) begin
        next_st.word_valid = 1'b0;
      end
      // [R8] Divide-by-two phase paces the demux
      if (demux_advance) begin
        if (st.demux_phase == HALF_LOW) begin
          // [R9] First edge holds the even bit
          next_st.even_hold = st.retimed;
          next_st.demux_phase = HALF_HIGH;
        end else begin
          // [R9] Second edge completes the word
          next_st.word = {st.retimed, st.even_hold};
          next_st.word_valid = 1'b1;
          next_st.demux_phase = HALF_LOW;
        end
      end
      // [R10] Lane exchange on request
      if (LANE_SWAP_I) begin
        lanes = {out_link.word[EVEN_LANE], out_link.word[ODD_LANE]};
      end
      // [R18] New word lands with the falling clock
      if (take) begin
        next_st.lane_bits = lanes;
        next_st.out_phase = HALF_LOW;
        next_st.valid = 1'b1;
      end else if (st.out_phase == HALF_LOW) begin
        next_st.out_phase = HALF_HIGH;
      end else begin
        next_st.valid = 1'b0;
      end
      // [R16] Separate full-rate retimed output
      // [R11] Shared polarity on all three data outputs
      // [R13] Independent output enables
      // [R17] Enable 1 drives, 0 mutes both legs
      next_st.full_pos = FULL_DATA_OUT_ENABLE_I && (st.retimed ^ invert);
      next_st.full_neg = FULL_DATA_OUT_ENABLE_I && !(st.retimed ^ invert);
      next_st.even_pos = HALF_DATA_OUT_ENABLE_I && (next_st.lane_bits[EVEN_LANE] ^ invert);
      next_st.even_neg = HALF_DATA_OUT_ENABLE_I && !(next_st.lane_bits[EVEN_LANE] ^ invert);
      next_st.odd_pos = HALF_DATA_OUT_ENABLE_I && (next_st.lane_bits[ODD_LANE] ^ invert);
      next_st.odd_neg = HALF_DATA_OUT_ENABLE_I && !(next_st.lane_bits[ODD_LANE] ^ invert);
      // [R15] Clock and lanes leave from the same edge
      next_st.hclk_pos = HALF_CLOCK_OUT_ENABLE_I && (next_st.out_phase == HALF_HIGH);
      next_st.hclk_neg = HALF_CLOCK_OUT_ENABLE_I && (next_st.out_phase == HALF_LOW);
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      st <= '0;
      st.lol <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign FULL_DATA_OUT_POS_O = st.full_pos;
  assign FULL_DATA_OUT_NEG_O = st.full_neg;
  assign EVEN_LANE_OUT_POS_O = st.even_pos;
  assign EVEN_LANE_OUT_NEG_O = st.even_neg;
  assign ODD_LANE_OUT_POS_O = st.odd_pos;
  assign ODD_LANE_OUT_NEG_O = st.odd_neg;
  assign HALF_CLOCK_OUT_POS_O = st.hclk_pos;
  assign HALF_CLOCK_OUT_NEG_O = st.hclk_neg;
  assign HALF_VALID_O = st.valid;
  assign LOSS_OF_LOCK_O = st.lol;
  assign OSC_ENABLE_O = st.osc_en;
  assign PUMP_DEFICIT_O = st.deficit;
  assign FOLLOWER_BIAS_O = st.bias;
  assign REF_TERM_SINGLE_O = st.term_single;
  assign REF_TERM_DIFF_O = st.term_diff;

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);

  band_onehot_a: assert property ( // [R1]
    osc_on |=> ($onehot(OSC_ENABLE_O) && (OSC_ENABLE_O[$past(BAND_SELECT_I) - 3'h1])))
    else $error("active band not decoded one-hot");
  band_off_a: assert property ( // [R19]
    !osc_on |=> ((OSC_ENABLE_O == '0) && LOSS_OF_LOCK_O && $stable(EVEN_LANE_OUT_POS_O)
      && $stable(ODD_LANE_OUT_POS_O) && $stable(HALF_CLOCK_OUT_POS_O)))
    else $error("off band not quiet");
  pump_fine_a: assert property ( // [R5]
    (!PUMP_COARSE_I && PUMP_FINE_I) |=> (PUMP_DEFICIT_O == PUMP_DEF_01))
    else $error("pump current code wrong");
  bias_track_a: assert property ( // [R6]
    osc_on |=> (FOLLOWER_BIAS_O == $past(FOLLOWER_CURRENT_I)))
    else $error("follower bias not tracking");
  ref_mode_a: assert property ( // [R12]
    REF_MODE_LVDS_I |=> (REF_TERM_DIFF_O && !REF_TERM_SINGLE_O))
    else $error("reference termination wrong");
  word_pair_a: assert property ( // [R9]
    (osc_on && demux_advance && (st.demux_phase == HALF_HIGH))
    |=> (demux_link.word == {$past(st.retimed), $past(st.even_hold)}) && demux_link.valid)
    else $error("demux word mispaired");
  lane_swap_a: assert property ( // [R10]
    (take && LANE_SWAP_I)
    |=> (st.lane_bits == {$past(out_link.word[EVEN_LANE]), $past(out_link.word[ODD_LANE])}))
    else $error("lane swap not applied");
  polarity_a: assert property ( // [R11]
    (osc_on && HALF_DATA_OUT_ENABLE_I && FULL_DATA_OUT_ENABLE_I)
    |=> ((EVEN_LANE_OUT_POS_O == (st.lane_bits[EVEN_LANE] ^ $past(invert)))
      && (FULL_DATA_OUT_POS_O == ($past(st.retimed) ^ $past(invert)))))
    else $error("output polarity wrong");
  mute_full_a: assert property ( // [R17]
    (osc_on && !FULL_DATA_OUT_ENABLE_I) |=> (!FULL_DATA_OUT_POS_O && !FULL_DATA_OUT_NEG_O))
    else $error("disabled full-rate output drives");
  fall_align_a: assert property ( // [R18]
    (osc_on && HALF_CLOCK_OUT_ENABLE_I && (st.lane_bits != next_st.lane_bits))
    |=> $fell(st.out_phase) && !HALF_CLOCK_OUT_POS_O)
    else $error("lane change off falling edge");
endmodule

// ---- verif/lane_sink_model.sv ----
// Downstream receiver model: takes lane words from the half-rate pins.
// Assumes it shares the system clock and watches the pins directly.
`timescale 1ns/1ps
module lane_sink_model (
  // Clock and reset
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  // Bench control
  input  wire logic  stall_i,
  // Lane pins
  input  wire logic  even_i,
  input  wire logic  odd_i,
  input  wire logic  half_clk_i,
  input  wire logic  valid_i,
  // Handshake and capture
  output logic       ready_o,
  output logic       new_word_o,
  output logic [1:0] word_o
);
  // Registered ready: a busy receiver answers one cycle late
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= !stall_i;
    end
  end
  // Fresh word shows as valid with the half clock low
  assign new_word_o = valid_i && !half_clk_i;
  assign word_o     = {odd_i, even_i};
endmodule

// ---- verif/cdr_demux_one_to_two_tb.sv ----
// Self-checking bench for the clock-recovery demultiplexer.
// Assumes the design's reference window is shortened to four periods.
`timescale 1ns/1ps
module cdr_demux_one_to_two_tb;
  import cdr_pkg::*;
  logic clk, rst, ser, ref_lvl, cf, ff, lvds, pol, swp, en_f, en_c, en_d, stall, rdy;
  logic [2:0] band;
  logic [7:0] bias;
  logic fp, fn, ep, en, op, on, cp, cn, hv, lol, ts, td, nw, prev_c, chk, flow, rec;
  logic [1:0] wd, prev_l;
  logic [5:0] osc;
  logic [4:0] dfc;
  logic [7:0] bias_o;
  logic hist[$];
  logic [1:0] words[$];
  int num_errors, compares, ref_cnt, ref_period, hn, base, i;
  logic [4:0] pump_tab [4] = '{5'h1F, 5'h1B, 5'h04, 5'h00};

  cdr_demux_one_to_two #(.PERIODS(4)) DUT (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .SERIAL_IN_POS_I(ser), .SERIAL_IN_NEG_I(!ser),
    .REFERENCE_CLOCK_POS_I(ref_lvl), .REFERENCE_CLOCK_NEG_I(lvds ? !ref_lvl : 1'b1),
    .BAND_SELECT_I(band), .PUMP_COARSE_I(cf), .PUMP_FINE_I(ff), .FOLLOWER_CURRENT_I(bias),
    .REF_MODE_LVDS_I(lvds), .POLARITY_DIRECT_I(pol), .LANE_SWAP_I(swp),
    .FULL_DATA_OUT_ENABLE_I(en_f), .HALF_CLOCK_OUT_ENABLE_I(en_c),
    .HALF_DATA_OUT_ENABLE_I(en_d), .HALF_READY_I(rdy), .FULL_DATA_OUT_POS_O(fp),
    .FULL_DATA_OUT_NEG_O(fn), .EVEN_LANE_OUT_POS_O(ep), .EVEN_LANE_OUT_NEG_O(en),
    .ODD_LANE_OUT_POS_O(op), .ODD_LANE_OUT_NEG_O(on), .HALF_CLOCK_OUT_POS_O(cp),
    .HALF_CLOCK_OUT_NEG_O(cn), .HALF_VALID_O(hv), .LOSS_OF_LOCK_O(lol),
    .OSC_ENABLE_O(osc), .PUMP_DEFICIT_O(dfc), .FOLLOWER_BIAS_O(bias_o),
    .REF_TERM_SINGLE_O(ts), .REF_TERM_DIFF_O(td));

  lane_sink_model sink (.clk_i(clk), .rst_i(rst), .stall_i(stall), .even_i(ep), .odd_i(op),
    .half_clk_i(cp), .valid_i(hv), .ready_o(rdy), .new_word_o(nw), .word_o(wd));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = !clk;
  end

  // reference at one thirty-second of the bit rate
  always @(posedge clk) begin
    ref_cnt <= (ref_cnt + 1 >= ref_period) ? 0 : ref_cnt + 1;
    ref_lvl <= (ref_cnt < ref_period / 2);
    ser     <= 1'($urandom);
  end

  // Monitor sees pre-edge outputs; the full-rate bit lags the pin by two edges
  always @(posedge clk) begin
    if (!rst) begin
      hist.push_back(ser);
      hn = hist.size();
      if (chk && hn > 2) begin
        check("full_pos", fp, en_f ? hist[hn-3] ^ !pol : 1'b0);
        check("full_neg", fn, en_f ? !(hist[hn-3] ^ !pol) : 1'b0);
        if (!en_d) check("lanes_mute", {ep, en, op, on}, 8'h00);
        if (!en_c) check("hclk_mute", {cp, cn}, 8'h00);
        if (flow && en_c) check("hclk_toggle", cp, !prev_c);
        if (en_c && en_d && {ep, op} != prev_l) check("lane_edge", {prev_c, cp}, 8'h02);
      end
      if (rec && nw) words.push_back(wd ^ {2{!pol}});
      prev_c = cp;
      prev_l = {ep, op};
    end
  end

  task automatic analyze(input logic sw);
    logic r[$];
    int k, off, j;
    off = -1;
    foreach (words[w]) begin
      r.push_back(sw ? words[w][1] : words[w][0]);
      r.push_back(sw ? words[w][0] : words[w][1]);
    end
    // receiver settles the word offset from the data itself, taking the lane order from the bench's swap setting
    for (k = 0; k < 24 && off < 0 && r.size() >= 24; k++) begin
      off = k;
      for (j = 0; j < 24; j++) if (r[j] !== hist[base + k + j]) off = -1;
    end
    check("word_align", 8'(off >= 0), 8'h01);
    for (j = 0; off >= 0 && j + 1 < r.size(); j += 2)
      check("lane_word", {r[j], r[j+1]}, {hist[base+off+j], hist[base+off+j+1]});
  endtask

  initial begin
    void'($urandom(32'hBA4F3AD3));
    {rst, ser, ref_lvl, cf, ff, lvds, pol, swp, stall, chk, flow, rec} = '0;
    {band, bias, ref_cnt, num_errors, compares, prev_c, prev_l} = '0;
    {en_f, en_c, en_d} = 3'h7;
    ref_period = 32;
    rst = 1'b1;
    tick(2);
    check("reset_alarm", lol, 8'h01);
    check("reset_outs", {fp, fn, ep, en, op, on, cp, cn}, 8'h00);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) begin
      band <= 3'(i);
      {cf, ff} <= 2'(i);
      lvds <= i[0];
      bias <= 8'($urandom);
      tick(2);
      check("osc_enable", osc, (i > 0 && i < 7) ? 6'h01 << (i - 1) : 6'h00);
      check("pump", dfc, pump_tab[i % 4]);
      check("bias", bias_o, (i > 0 && i < 7) ? bias : 8'h00);
      check("term", {ts, td}, i[0] ? 8'h01 : 8'h02);
      if (i == 0 || i == 7) check("off_alarm", lol, 8'h01);
    end
    for (i = 0; i < 7; i++) begin
      chk <= 1'b0;
      flow <= 1'b0;
      band <= 3'h3;
      {pol, swp} <= (i < 4) ? 2'(i) : 2'h2;
      {en_f, en_c, en_d} <= (i < 4) ? 3'h7 : 3'h7 ^ (3'h1 << (i - 4));
      tick(8);
      chk <= 1'b1;
      flow <= 1'b1;
      rec <= (i < 4);
      words.delete();
      base = hist.size() - 12;
      tick(120);
      rec <= 1'b0;
      tick(1);
      if (i < 4) analyze(swp);
    end
    flow <= 1'b0;
    stall <= 1'b1;
    tick(4);
    prev_l = {ep, op};
    for (i = 0; i < 8; i++) begin
      check("stall_hold", {hv, cp, ep, op}, {2'b01, prev_l});
      tick(1);
    end
    stall <= 1'b0;
    chk <= 1'b0;
    band <= 3'h0;
    tick(3);
    prev_l = {ep, op};
    for (i = 0; i < 10; i++) begin
      check("off_static", {lol, ep, op}, {1'b1, prev_l});
      tick(1);
    end
    band <= 3'h6;
    for (i = 0; i < 800 && lol !== 1'b0; i++) tick(1);
    check("lock_gain", lol, 8'h00);
    for (i = 0; i < 300; i++) begin
      if (lol !== 1'b0) check("lock_hold", lol, 8'h00);
      tick(1);
    end
    ref_period = 33;
    for (i = 0; i < 800 && lol !== 1'b1; i++) tick(1);
    check("lock_loss", lol, 8'h01);
    end_of_test();
  end

  initial begin
    tick(20000);
    num_errors++;
    end_of_test();
  end
endmodule
